// file: drs_ctrl.sv
// Controller end: issues link commands, enforces refresh spacing and counts.
// Assumes the memory end samples the link on the same clock edge.
//
// Summary of operation
// - Refresh: CS low, CA0 CA1 low, CA2 high
// - CA3 low single bank, high all banks
// - Single-bank refresh only on eight-bank parts
// - Device bank counter steps 0 to 7, wraps
// - Counter zeroed by RESET and self-refresh exit
// - All-bank refresh also zeroes the counter
// - Controller mirrors the round-robin bank pointer
// - Refresh only idle banks; none open for all
// - Single-bank refresh waits all four spacings
// - Refreshing bank locked; other banks stay usable
// - After single refresh: spacing before next uses
// - All banks idle before all-bank refresh
// - All-bank refresh waits both cycles and precharge
// - After all-bank refresh: wait before activate, refresh
// - Required refresh count in every refresh window
// - Eight single refreshes count as one
// - At most eight all-bank refreshes per burst window
// - Self-refresh time reduces required count, rounded up
// - Regular schedule: one refresh per average interval
// - Burst schedule: full count fast, then pause
// - Schedule switch must keep every window satisfied
// - Enter self refresh only after a burst; code checks this in burst mode only
`timescale 1ns/10ps
`default_nettype none
module drs_ctrl #(
  parameter int NUM_BANKS = drs_pkg::MAX_BANKS,
  parameter int T_RFCAB_NS = drs_pkg::T_RFCAB_NS,
  parameter int T_RFCPB_NS = drs_pkg::T_RFCPB_NS,
  parameter int T_RP_NS = drs_pkg::T_RP_NS,
  parameter int T_RRD_NS = drs_pkg::T_RRD_NS,
  parameter int T_REFI_NS = drs_pkg::T_REFI_NS,
  parameter int REFW_CYC =
    drs_pkg::cycles_min(drs_pkg::T_REFW_MS * drs_pkg::NS_PER_MS),
  parameter int REQUIRED = drs_pkg::REQ_REFRESHES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire drs_pkg::drs_op_t cmd_op,
  input wire logic [drs_pkg::BANK_W-1:0] cmd_bank,
  input wire logic burst_mode,
  output logic cmd_done,
  output logic cmd_reject,
  output logic refresh_due,
  output logic window_short,
  output logic in_self_refresh,
  output logic [drs_pkg::BANK_W-1:0] bank_ptr,
  drs_if.ctrl bus
);
  import drs_pkg::*;

  // Spacings as whole cycles of this clock
  localparam int AB_CYC = cycles_min(T_RFCAB_NS);
  localparam int PB_CYC = cycles_min(T_RFCPB_NS);
  localparam int RP_CYC = cycles_min(T_RP_NS);
  localparam int RRD_CYC = cycles_min(T_RRD_NS);
  localparam int REFI_CYC = cycles_max(T_REFI_NS);
  localparam int BW_CYC = BURST_WINDOW_MULT * AB_CYC;
  localparam int WIN_W = $clog2(REFW_CYC + 1);
  localparam int CR_W = $clog2(REQUIRED + 1) + 1;
  localparam int RI_W = $clog2(REFI_CYC + 1);
  localparam logic [TIMER_W-1:0] AB_LD = TIMER_W'(AB_CYC - 1);
  localparam logic [TIMER_W-1:0] PB_LD = TIMER_W'(PB_CYC - 1);
  localparam logic [TIMER_W-1:0] RP_LD = TIMER_W'(RP_CYC - 1);
  localparam logic [TIMER_W-1:0] RRD_LD = TIMER_W'(RRD_CYC - 1);
  localparam logic [STAMP_W-1:0] BW_SPAN = STAMP_W'(BW_CYC);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(REFW_CYC - 1);
  localparam logic [RI_W-1:0] RI_LAST = RI_W'(REFI_CYC - 1);
  localparam logic [CR_W:0] REQ_CR = (CR_W+1)'(REQUIRED);
  localparam logic [BANK_W-1:0] LAST_BANK = BANK_W'(PB_PER_ROUND - 1);
  localparam logic [3:0] FILL_MAX = 4'(BURST_LIMIT);

  generate
    if (NUM_BANKS != 4 && NUM_BANKS != MAX_BANKS)
      $error("drs_ctrl: NUM_BANKS must be 4 or 8");
    if (AB_CYC >= (1 << TIMER_W) || PB_CYC >= (1 << TIMER_W) ||
        RP_CYC >= (1 << TIMER_W) || RRD_CYC >= (1 << TIMER_W))
      $error("drs_ctrl: spacing too long for timer");
    if (BW_CYC >= (1 << (STAMP_W - 1)) || REFW_CYC < 2)
      $error("drs_ctrl: window length out of range");
  endgenerate

  logic [TIMER_W-1:0] ab_wait;
  logic [TIMER_W-1:0] pb_wait;
  logic [TIMER_W-1:0] rrd_wait;
  logic [TIMER_W-1:0] rp_wait [MAX_BANKS];
  logic [BANK_W-1:0] pb_bank;
  logic [MAX_BANKS-1:0] open;
  logic [STAMP_W-1:0] now;
  logic [STAMP_W-1:0] stamp [BURST_LIMIT];
  logic [$clog2(BURST_LIMIT)-1:0] stamp_wp;
  logic [3:0] ab_fill;
  logic [WIN_W-1:0] win_cnt;
  logic [CR_W-1:0] credits;
  logic [CR_W-1:0] sr_credit;
  logic [RI_W-1:0] refi_ph;
  logic [RI_W-1:0] since_ref;

  // Link command encoder
  function automatic logic [CA_W-1:0] encode(input drs_op_t op,
                                             input logic [BANK_W-1:0] b);
    logic [CA_W-1:0] c;
    c = '0;
    unique case (op)
      DRS_ACT: begin
        c[CA_BIT1] = 1'b1;
        c[CA_BANK_LO +: BANK_W] = b;
      end
      DRS_PRE, DRS_PREA: begin
        c[CA_BIT0] = 1'b1;
        c[CA_BIT1] = 1'b1;
        c[CA_BIT3] = 1'b1;
        c[CA_ALL_BIT] = (op == DRS_PREA);
        c[CA_BANK_LO +: BANK_W] = b;
      end
      DRS_REF_ONE, DRS_SRE: c[CA_BIT2] = 1'b1;
      DRS_REF_ALL: begin
        c[CA_BIT2] = 1'b1;
        c[CA_BIT3] = 1'b1;
      end
      DRS_RESET: c[CA_MA_LO +: CA_MA_W] = MA_RESET;
      default: c = '0;
    endcase
    return c;
  endfunction : encode

  ////////////////////////////////////////////////////////////////////////////
  // Legality of the offered command
  logic legal;
  logic all_rp_done;
  logic burst_ok;
  logic quota_met;
  logic accept;

  always_comb begin
    all_rp_done = 1'b1;
    for (int i = 0; i < MAX_BANKS; i++) begin
      if (rp_wait[i] != '0) all_rp_done = 1'b0;
    end
  end

  // Ninth all-bank refresh needs the oldest of eight to age out
  assign burst_ok = (ab_fill < FILL_MAX) ||
                    (STAMP_W'(now - stamp[stamp_wp]) >= BW_SPAN);
  // Required count less self-refresh credit
  assign quota_met = ({1'b0, credits} + {1'b0, sr_credit}) >= REQ_CR;

  always_comb begin
    legal = 1'b0;
    unique case (cmd_op)
      DRS_NOP: legal = 1'b1;
      DRS_ACT: legal = !in_self_refresh && ab_wait == '0
                 && rrd_wait == '0 && rp_wait[cmd_bank] == '0
                 && !open[cmd_bank] && 32'(cmd_bank) < NUM_BANKS
                 && !(pb_wait != '0 && pb_bank == cmd_bank);
      DRS_PRE: legal = !in_self_refresh && 32'(cmd_bank) < NUM_BANKS;
      DRS_PREA: legal = !in_self_refresh;
      DRS_REF_ONE: legal = !in_self_refresh
                 && NUM_BANKS == MAX_BANKS
                 && ab_wait == '0 && pb_wait == '0 && rrd_wait == '0
                 && rp_wait[bank_ptr] == '0
                 && !open[bank_ptr];
      DRS_REF_ALL: legal = !in_self_refresh && open == '0
                 && ab_wait == '0 && pb_wait == '0
                 && all_rp_done && burst_ok;
      DRS_RESET: legal = !in_self_refresh;
      DRS_SRE: legal = !in_self_refresh && open == '0 && ab_wait == '0
                 && pb_wait == '0 && all_rp_done
                 && (!burst_mode || quota_met);
      DRS_SRX: legal = in_self_refresh;
      default: legal = 1'b0;
    endcase
  end

  assign accept = cmd_valid && legal && cmd_op != DRS_NOP;

  ////////////////////////////////////////////////////////////////////////////
  // Link drive and user answer, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.cs_n <= 1'b1;
      bus.cke <= 1'b1;
      bus.ca <= '0;
      cmd_done <= 1'b0;
      cmd_reject <= 1'b0;
      in_self_refresh <= 1'b0;
    end else begin
      cmd_done <= cmd_valid && legal;
      cmd_reject <= cmd_valid && !legal;
      bus.cs_n <= !(accept && cmd_op != DRS_SRX);
      bus.ca <= accept ? encode(cmd_op, cmd_bank) : '0;
      if (accept && cmd_op == DRS_SRE) begin
        bus.cke <= 1'b0;
        in_self_refresh <= 1'b1;
      end else if (accept && cmd_op == DRS_SRX) begin
        bus.cke <= 1'b1;
        in_self_refresh <= 1'b0;
      end
    end
  end

  // Mirror of the memory's round-robin pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_ptr <= '0;
    end else if (accept && (cmd_op == DRS_RESET || cmd_op == DRS_SRX ||
                            cmd_op == DRS_REF_ALL)) begin
      bank_ptr <= '0;
    end else if (accept && cmd_op == DRS_REF_ONE) begin
      bank_ptr <= bank_ptr + 1'b1;
    end
  end

  // Open-bank tracking; reset command closes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open <= '0;
    end else if (accept) begin
      unique case (cmd_op)
        DRS_ACT: open[cmd_bank] <= 1'b1;
        DRS_PRE: open[cmd_bank] <= 1'b0;
        DRS_PREA, DRS_RESET: open <= '0;
        default: open <= open;
      endcase
    end
  end

  // Spacing timers; load is spacing minus one, legal at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_wait <= '0;
      pb_wait <= '0;
      rrd_wait <= '0;
      pb_bank <= '0;
    end else begin
      if (accept && cmd_op == DRS_REF_ALL) ab_wait <= AB_LD;
      else if (ab_wait != '0) ab_wait <= ab_wait - 1'b1;
      if (accept && cmd_op == DRS_REF_ONE) begin
        pb_wait <= PB_LD;
        pb_bank <= bank_ptr;
      end else if (pb_wait != '0) begin
        pb_wait <= pb_wait - 1'b1;
      end
      // Other banks need only activate spacing after a single refresh
      if (accept && (cmd_op == DRS_ACT || cmd_op == DRS_REF_ONE))
        rrd_wait <= RRD_LD;
      else if (rrd_wait != '0) rrd_wait <= rrd_wait - 1'b1;
    end
  end

  // Per-bank precharge timers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MAX_BANKS; i++) rp_wait[i] <= '0;
    end else begin
      for (int i = 0; i < MAX_BANKS; i++) begin
        if (accept && (cmd_op == DRS_PREA ||
            (cmd_op == DRS_PRE && cmd_bank == BANK_W'(i))))
          rp_wait[i] <= RP_LD;
        else if (rp_wait[i] != '0)
          rp_wait[i] <= rp_wait[i] - 1'b1;
      end
    end
  end

  // Rolling burst window: stamps of the last eight all-bank refreshes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      now <= '0;
      stamp_wp <= '0;
      ab_fill <= '0;
      for (int i = 0; i < BURST_LIMIT; i++) stamp[i] <= '0;
    end else begin
      now <= now + 1'b1;
      if (accept && cmd_op == DRS_REF_ALL) begin
        stamp[stamp_wp] <= now;
        stamp_wp <= stamp_wp + 1'b1;
        if (ab_fill < FILL_MAX) ab_fill <= ab_fill + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh accounting per window; windows are fixed, not sliding
  logic credit_ev;
  logic win_end;
  assign credit_ev = accept && (cmd_op == DRS_REF_ALL ||
                     (cmd_op == DRS_REF_ONE && bank_ptr == LAST_BANK));
  assign win_end = win_cnt == WIN_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= '0;
      credits <= '0;
      sr_credit <= '0;
      refi_ph <= '0;
      window_short <= 1'b0;
    end else begin
      win_cnt <= win_end ? '0 : win_cnt + 1'b1;
      refi_ph <= (refi_ph == RI_LAST) ? '0 : refi_ph + 1'b1;
      window_short <= win_end && !quota_met;
      if (win_end) begin
        credits <= '0;
        sr_credit <= '0;
      end else begin
        // Counts stop once the top bit is set, above the quota; more gains nothing
        if (credit_ev && !credits[CR_W-1]) credits <= credits + 1'b1;
        // Each started interval in self refresh earns one credit
        if (in_self_refresh && refi_ph == '0 && !sr_credit[CR_W-1])
          sr_credit <= sr_credit + 1'b1;
      end
    end
  end

  // Due hint: regular every interval, or burst until quota is met
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_ref <= '0;
      refresh_due <= 1'b0;
    end else begin
      // Interval restarts at each counted refresh, so leaving a burst is safe
      if (credit_ev) since_ref <= '0;
      else if (since_ref != RI_LAST) since_ref <= since_ref + 1'b1;
      if (burst_mode)
        refresh_due <= !in_self_refresh && !quota_met && burst_ok;
      else
        refresh_due <= !in_self_refresh && since_ref == RI_LAST;
    end
  end

endmodule : drs_ctrl
`default_nettype wire

// file: drs_pkg.sv
// Shared constants and types for the refresh scheduling link.
// Assumes a single 10 MHz clock shared by controller and memory end.
package drs_pkg;

  // Clock and bus geometry
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int CA_W = 10;
  localparam int BANK_W = 3;
  localparam int MAX_BANKS = 8;
  localparam int TIMER_W = 8;
  localparam int STAMP_W = 16;

  // Command/address bit positions
  localparam int CA_BIT0 = 0;
  localparam int CA_BIT1 = 1;
  localparam int CA_BIT2 = 2;
  localparam int CA_BIT3 = 3;
  localparam int CA_ALL_BIT = 4;
  localparam int CA_BANK_LO = 7;
  localparam int CA_MA_LO = 4;
  localparam int CA_MA_W = 6;
  localparam logic [CA_MA_W-1:0] MA_RESET = 6'h3f;
  localparam logic [3:0] CA_LOW_ZERO = 4'h0;

  // Timing figures as printed or chosen
  localparam int T_RFCAB_NS = 130;
  localparam int T_RFCPB_NS = 60;
  localparam int T_RP_NS = 18;
  localparam int T_RRD_NS = 10;
  localparam int T_REFI_NS = 7800;
  localparam int T_REFW_MS = 32;
  localparam int REQ_REFRESHES = 4096;
  localparam int BURST_LIMIT = 8;
  localparam int BURST_WINDOW_MULT = 32;
  localparam int PB_PER_ROUND = 8;

  // User-side command codes
  typedef enum logic [3:0] {
    DRS_NOP, DRS_ACT, DRS_PRE, DRS_PREA, DRS_REF_ONE,
    DRS_REF_ALL, DRS_RESET, DRS_SRE, DRS_SRX
  } drs_op_t;

  // Least time: round up, never below one cycle
  function automatic int cycles_min(input int ns);
    int r;
    r = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (r < 1) ? 1 : r;
  endfunction : cycles_min

  // Longest time: round down, never below one cycle
  function automatic int cycles_max(input int ns);
    int r;
    r = ns / CLK_PERIOD_NS;
    return (r < 1) ? 1 : r;
  endfunction : cycles_max

endpackage : drs_pkg

// file: drs_if.sv
// Command/address link between refresh controller and memory end.
// Assumes both ends sample on the same rising clock edge.
`timescale 1ns/10ps
`default_nettype none
interface drs_if;
  logic cs_n;
  logic cke;
  logic [drs_pkg::CA_W-1:0] ca;
  modport ctrl (output cs_n, output cke, output ca);
  modport mem (input cs_n, input cke, input ca);
endinterface : drs_if
`default_nettype wire

// file: drs_device.sv
// Memory end: decodes refresh commands, keeps the round-robin bank counter.
// Assumes the controller keeps all spacing; violations only raise flags.
`timescale 1ns/10ps
`default_nettype none
module drs_device #(
  parameter int NUM_BANKS = drs_pkg::MAX_BANKS,
  parameter int T_RFCAB_NS = drs_pkg::T_RFCAB_NS,
  parameter int T_RFCPB_NS = drs_pkg::T_RFCPB_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  drs_if.mem bus,
  output logic ref_pulse,
  output logic ref_all,
  output logic [drs_pkg::BANK_W-1:0] ref_bank,
  output logic [drs_pkg::BANK_W-1:0] bank_ptr,
  output logic self_refresh,
  output logic access_conflict,
  output logic illegal_refresh
);
  import drs_pkg::*;

  localparam int AB_CYC = cycles_min(T_RFCAB_NS);
  localparam int PB_CYC = cycles_min(T_RFCPB_NS);
  localparam logic [TIMER_W-1:0] AB_LD = TIMER_W'(AB_CYC - 1);
  localparam logic [TIMER_W-1:0] PB_LD = TIMER_W'(PB_CYC - 1);

  generate
    if (NUM_BANKS != 4 && NUM_BANKS != MAX_BANKS)
      $error("drs_device: NUM_BANKS must be 4 or 8");
    if (AB_CYC >= (1 << TIMER_W) || PB_CYC >= (1 << TIMER_W))
      $error("drs_device: refresh cycle time too long for timer");
  endgenerate

  logic cke_prev;
  logic [TIMER_W-1:0] pb_busy;
  logic [TIMER_W-1:0] ab_busy;
  logic [BANK_W-1:0] busy_bank;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic sel;
  logic ref_enc;
  logic act_enc;
  logic rst_enc;
  logic do_ref;
  logic do_pb;
  logic do_ab;
  logic sr_entry;
  logic sr_exit;
  logic [BANK_W-1:0] act_bank;

  // Refresh encoding shared by refresh and self-refresh entry
  assign sel = !bus.cs_n && !self_refresh;
  assign ref_enc = sel && !bus.ca[CA_BIT0] && !bus.ca[CA_BIT1]
                   && bus.ca[CA_BIT2];
  assign act_enc = sel && bus.cke && !bus.ca[CA_BIT0] && bus.ca[CA_BIT1];
  assign rst_enc = sel && bus.cke && bus.ca[CA_MA_LO-1:0] == CA_LOW_ZERO
                   && bus.ca[CA_MA_LO +: CA_MA_W] == MA_RESET;
  assign do_ref = ref_enc && cke_prev && bus.cke;
  assign do_pb = do_ref && !bus.ca[CA_BIT3];
  assign do_ab = do_ref && bus.ca[CA_BIT3];
  assign sr_entry = ref_enc && cke_prev && !bus.cke;
  assign sr_exit = self_refresh && bus.cke;
  assign act_bank = bus.ca[CA_BANK_LO +: BANK_W];

  ////////////////////////////////////////////////////////////////////////////
  // Clock-enable history and self-refresh state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev <= 1'b0;
      self_refresh <= 1'b0;
    end else begin
      cke_prev <= bus.cke;
      if (sr_entry) begin
        self_refresh <= 1'b1;
      end else if (sr_exit) begin
        self_refresh <= 1'b0;
      end
    end
  end

  // Round-robin pointer; every resync point forces bank 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_ptr <= '0;
    end else if (rst_enc || sr_exit) begin
      bank_ptr <= '0;
    end else if (do_ab) begin
      bank_ptr <= '0;
    end else if (do_pb && NUM_BANKS == MAX_BANKS) begin
      bank_ptr <= bank_ptr + 1'b1;
    end
  end

  // Refresh report; single-bank form is refused on small parts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_pulse <= 1'b0;
      ref_all <= 1'b0;
      ref_bank <= '0;
      illegal_refresh <= 1'b0;
    end else begin
      ref_pulse <= do_ab || (do_pb && NUM_BANKS == MAX_BANKS);
      ref_all <= do_ab;
      ref_bank <= do_ab ? '0 : bank_ptr;
      illegal_refresh <= do_pb && NUM_BANKS != MAX_BANKS;
    end
  end

  // Busy timers: refreshed bank locked, others stay usable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_busy <= '0;
      ab_busy <= '0;
      busy_bank <= '0;
    end else begin
      if (do_pb && NUM_BANKS == MAX_BANKS) begin
        pb_busy <= PB_LD;
        busy_bank <= bank_ptr;
      end else if (pb_busy != '0) begin
        pb_busy <= pb_busy - 1'b1;
      end
      if (do_ab) begin
        ab_busy <= AB_LD;
      end else if (ab_busy != '0) begin
        ab_busy <= ab_busy - 1'b1;
      end
    end
  end

  // Activate into a bank still refreshing is flagged, not served
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      access_conflict <= 1'b0;
    end else begin
      access_conflict <= act_enc && (ab_busy != '0 ||
                         (pb_busy != '0 && act_bank == busy_bank));
    end
  end

endmodule : drs_device
`default_nettype wire

// file: drs_link_sva.sv
// Assertions on the refresh command link wires.
// Assumes one shared clock; instantiated beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module drs_link_sva #(
  parameter int NUM_BANKS = drs_pkg::MAX_BANKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic cke,
  input wire logic [drs_pkg::CA_W-1:0] ca
);
  import drs_pkg::*;
  logic ref_cmd;
  logic ab_ref;
  logic pb_ref;
  logic act_cmd;
  logic [62:0] ab_hist;

  // Wire decode; activate and refresh differ in ca[1:0], never overlap
  assign ref_cmd = !cs_n && cke && !ca[CA_BIT0] && !ca[CA_BIT1]
                   && ca[CA_BIT2];
  assign ab_ref = ref_cmd && ca[CA_BIT3];
  assign pb_ref = ref_cmd && !ca[CA_BIT3];
  assign act_cmd = !cs_n && cke && !ca[CA_BIT0] && ca[CA_BIT1];

  // Past 63 cycles of all-bank refreshes, for the rolling current cap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_hist <= '0;
    end else begin
      ab_hist <= {ab_hist[61:0], ab_ref};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ref_cke; ref_cmd |-> $past(cke); endproperty
  a_ref_cke: assert property (p_ref_cke)
    else $error("refresh without cke high before");
  property p_sre_frame;
    $fell(cke) |-> (!cs_n && !ca[CA_BIT0] && !ca[CA_BIT1] && ca[CA_BIT2])
      ##1 cs_n;
  endproperty
  a_sre_frame: assert property (p_sre_frame)
    else $error("bad self refresh entry frame");
  property p_pb_banks; pb_ref |-> NUM_BANKS == MAX_BANKS; endproperty
  a_pb_banks: assert property (p_pb_banks)
    else $error("single bank refresh on small part");
  property p_act_ab; act_cmd |=> !ab_ref; endproperty
  a_act_ab: assert property (p_act_ab)
    else $error("all bank refresh with a bank open");
  property p_ab_act; ab_ref |-> ##1 !act_cmd; endproperty
  a_ab_act: assert property (p_ab_act)
    else $error("activate too soon after all bank refresh");
  property p_ab_ref; ab_ref |=> !ref_cmd; endproperty
  a_ab_ref: assert property (p_ab_ref)
    else $error("refresh too soon after all bank refresh");
  property p_ab_gap; ab_ref |-> !$past(ab_ref); endproperty
  a_ab_gap: assert property (p_ab_gap)
    else $error("all bank refreshes too close");
  property p_burst;
    ab_ref |-> $countones({ab_hist, ab_ref}) <= BURST_LIMIT;
  endproperty
  a_burst: assert property (p_burst)
    else $error("too many all bank refreshes in burst window");

  // Main scenarios reached
  c_pb_pair: cover property (pb_ref ##1 pb_ref);
  c_sre: cover property ($fell(cke));
  c_burst_full: cover property ($countones({ab_hist, ab_ref}) == BURST_LIMIT);
endmodule : drs_link_sva
`default_nettype wire

// file: dram_refresh_scheduling_tb.sv
// Testbench: controller and memory end joined by the link interface.
// Assumes a 10 MHz clock and short refresh windows for simulation.
`timescale 1ns/10ps
`default_nettype none
module dram_refresh_scheduling_tb;
  import drs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  drs_op_t cmd_op = DRS_NOP;
  logic [2:0] cmd_bank = 3'h0;
  logic burst_mode = 1'b0;
  logic cmd_done, cmd_reject, refresh_due, window_short, in_self_refresh;
  logic ref_pulse, ref_all, self_refresh, access_conflict, illegal_refresh;
  logic [2:0] c_ptr, d_ptr, ref_bank, m_ptr, rb;
  logic [1:0] ans_q[$];
  logic [3:0] ref_q[$];
  logic [1:0] ea;
  logic [3:0] er;
  logic [31:0] lfsr = 32'h12b4;
  int bad_count = 0;
  int n_checks = 0;
  int shorts = 0;

  drs_if drs_if_i ();
  drs_ctrl #(.REFW_CYC(400), .REQUIRED(4)) drs_ctrl_i (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_bank(cmd_bank), .burst_mode(burst_mode), .cmd_done(cmd_done),
    .cmd_reject(cmd_reject), .refresh_due(refresh_due),
    .window_short(window_short), .in_self_refresh(in_self_refresh),
    .bank_ptr(c_ptr), .bus(drs_if_i));
  drs_device drs_device_i (
    .clk(clk), .rst_n(rst_n), .bus(drs_if_i), .ref_pulse(ref_pulse),
    .ref_all(ref_all), .ref_bank(ref_bank), .bank_ptr(d_ptr),
    .self_refresh(self_refresh), .access_conflict(access_conflict),
    .illegal_refresh(illegal_refresh));
  drs_link_sva #(.NUM_BANKS(8)) drs_link_sva_i (
    .clk(clk), .rst_n(rst_n), .cs_n(drs_if_i.cs_n), .cke(drs_if_i.cke),
    .ca(drs_if_i.ca));

  // 100 ns period
  always #50 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic check(input string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Offer one request; the pointer model mirrors what the device will do
  task automatic req(input drs_op_t op, logic [2:0] b, logic rej);
    @(posedge clk);
    #2;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_bank = b;
    lfsr = lfsr_next(lfsr);
    ans_q.push_back({rej, !rej});
    if (!rej && op == DRS_REF_ONE) begin
      ref_q.push_back({1'b0, m_ptr});
      m_ptr++;
    end else if (!rej && op inside {DRS_REF_ALL, DRS_RESET, DRS_SRX}) begin
      if (op == DRS_REF_ALL) ref_q.push_back(4'h8);
      m_ptr = 3'h0;
    end
  endtask : req

  // Idle cycles; the ignored bank field still moves
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      cmd_op = DRS_NOP;
      cmd_bank = lfsr[2:0];
      lfsr = lfsr_next(lfsr);
    end
  endtask : idle

  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Results are matched against the oldest note, in arrival order
  always @(posedge clk) begin
    #1;
    if (cmd_done === 1'b1 || cmd_reject === 1'b1) begin
      ea = (ans_q.size() > 0) ? ans_q.pop_front() : 2'h0;
      check("answer", {6'h0, ea}, {6'h0, cmd_reject, cmd_done});
    end
    if (ref_pulse === 1'b1) begin
      er = (ref_q.size() > 0) ? ref_q.pop_front() : 4'hf;
      check("refresh", {4'h0, er}, {4'h0, ref_all, ref_bank});
    end
    if ((access_conflict | illegal_refresh) !== 1'b0)
      check("flags", 8'h0,
            {6'h0, access_conflict, illegal_refresh});
    if (window_short === 1'b1) shorts++;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    m_ptr = 3'h0;
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    idle(2);
    req(DRS_RESET, 3'h0, 1'b0);
    idle(80);
    check("due", 8'h1, {7'h0, refresh_due});
    for (int i = 0; i < 9; i++) req(DRS_REF_ONE, lfsr[2:0], 1'b0);
    idle(3);
    check("due", 8'h0, {7'h0, refresh_due});
    check("ptrs", {2'h0, m_ptr, m_ptr}, {2'h0, c_ptr, d_ptr});
    // Spacing and open-bank refusals, random open bank
    rb = lfsr[2:0];
    req(DRS_REF_ALL, rb, 1'b0);
    req(DRS_REF_ALL, rb, 1'b1);
    req(DRS_ACT, rb, 1'b0);
    req(DRS_REF_ALL, rb, 1'b1);
    req(DRS_REF_ONE, rb, rb == 3'h0);
    req(DRS_ACT, rb, 1'b1);
    req(DRS_PREA, rb, 1'b0);
    req(DRS_REF_ALL, rb, 1'b0);
    req(DRS_REF_ONE, rb, 1'b1);
    req(DRS_ACT, 3'h0, 1'b0);
    req(DRS_REF_ONE, rb, 1'b1);
    req(DRS_PREA, rb, 1'b0);
    // Burst cap: ninth all-bank refresh in the window is refused
    idle(70);
    for (int i = 0; i < 9; i++) begin
      req(DRS_REF_ALL, rb, i == 8);
      idle(1);
    end
    idle(70);
    req(DRS_REF_ALL, rb, 1'b0);
    // One spare cycle covers the all-bank cycle time before single refresh
    idle(1);
    for (int i = 0; i < 3; i++) req(DRS_REF_ONE, rb, 1'b0);
    idle(3);
    // Self refresh exit zeroes both pointers
    req(DRS_SRE, rb, 1'b0);
    req(DRS_ACT, rb, 1'b1);
    idle(3);
    check("self ref", 8'h3, {6'h0, in_self_refresh, self_refresh});
    req(DRS_SRX, rb, 1'b0);
    idle(3);
    check("ptrs", 8'h0, {2'h0, c_ptr, d_ptr});
    req(DRS_REF_ONE, rb, 1'b0);
    // Starved windows must be flagged
    idle(3);
    burst_mode = 1'b1;
    shorts = 0;
    idle(820);
    check("short", 8'h1, {7'h0, shorts > 0});
    burst_mode = 1'b0;
    idle(4);
    check("pending", 8'h0, 8'(ans_q.size() + ref_q.size()));
    give_verdict();
  end

  // Watchdog, nearly three times the expected run
  initial begin
    #(100 * 3000);
    bad_count++;
    give_verdict();
  end
endmodule : dram_refresh_scheduling_tb
`default_nettype wire
